/* inc/lus_consts.vh */
`ifndef LUS_CONSTS_VH
`define LUS_CONSTS_VH
// =====================================================================
// register byte offsets
`define LUS_OFF_CTRL     8'h00
`define LUS_OFF_ADSC     8'h04
`define LUS_OFF_STAT     8'h08
`define LUS_OFF_TXD      8'h0C
`define LUS_OFF_RXD      8'h10
`define LUS_OFF_EXT      8'h14
`define LUS_OFF_BAUD     8'h18
// =====================================================================
// serial_control_reg fields
`define LUS_CTL_TXEN     0
`define LUS_CTL_RXEN     1
`define LUS_CTL_CLRERR   2
`define LUS_CTL_ADSEL    3
`define LUS_CTL_MODE_LO  4
`define LUS_CTL_MODE_HI  5
`define LUS_CTL_PRST     6
`define LUS_CTL_MSB      7
`define LUS_CTL_CH7      8
// address/data set and clear strobes
`define LUS_ADSC_SET     0
`define LUS_ADSC_CLR     1
// status fields
`define LUS_ST_TXEMPTY   0
`define LUS_ST_RXFULL    1
`define LUS_ST_FRAMERR   2
`define LUS_ST_BRKDET    3
`define LUS_ST_RXADB     4
`define LUS_ST_TXIE      5
`define LUS_ST_BRKIE     6
`define LUS_ST_IDLE      7
// extended feature fields
`define LUS_EXT_BRKEDGE  0
`define LUS_EXT_RXPROT   1
`define LUS_EXT_STARTOPT 2
`define LUS_EXT_HDRTX    3
`define LUS_EXT_BRKREQ   4
`define LUS_EXT_SLAVE    5
`define LUS_EXT_BLEN_LO  6
`define LUS_EXT_BLEN_HI  7
// =====================================================================
// reset values
`define LUS_BAUD_RST     16'h043C
`define LUS_TDR_RST      8'hFF
`define LUS_RDR_RST      8'h00
// operating modes
`define LUS_MODE_ASYNC   2'h0
`define LUS_MODE_MULTI   2'h1
`define LUS_MODE_SYNC    2'h2
`define LUS_MODE_LIN     2'h3
// timing in bit times, and the sync field value
`define LUS_BRK_RX_BITS  4'hA
`define LUS_BRK_TX_BASE  5'h0D
`define LUS_IDLE_BITS    4'hB
`define LUS_SYNC_BYTE    8'h55
// bus responses
`define LUS_RESP_OK      2'h0
`define LUS_RESP_ERR     2'h2
`endif

/* src/lus_pin_sync.v */
`timescale 1ns/1ps
// =====================================================================
// pin synchroniser: three flops, level taken when stages two and three agree
module lus_pin_sync (
  input  wire ref_clk,
  input  wire rst,
  input  wire pin_in,
  output reg  level_reg,
  output reg  fall_reg
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // idle line is high, so reset to high to avoid a false edge
  always @(posedge ref_clk) begin
    if (rst) begin
      s1_reg    <= 1'b1;
      s2_reg    <= 1'b1;
      s3_reg    <= 1'b1;
      level_reg <= 1'b1;
      fall_reg  <= 1'b0;
    end else begin
      s1_reg   <= pin_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      fall_reg <= (s2_reg == s3_reg) & level_reg & ~s3_reg;
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end
endmodule // lus_pin_sync

/* src/lus_top.v */
`timescale 1ns/1ps
`include "lus_consts.vh"
module lus_top (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        serial_receive_input,
  output wire        serial_transmit_output,
  output wire        tx_irq,
  output wire        break_irq
);
  localparam T_IDLE = 2'h0, T_BRK = 2'h1, T_DEL = 2'h2, T_SHIFT = 2'h3;
  localparam R_IDLE = 2'h0, R_START = 2'h1, R_DATA = 2'h2, R_STOP = 2'h3;
  localparam H_IDLE = 2'h0, H_SYNC = 2'h1, H_ID = 2'h2;

  // register index for an offset, 7 when unmapped
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `LUS_OFF_CTRL: reg_sel = 3'h0;
        `LUS_OFF_ADSC: reg_sel = 3'h1;
        `LUS_OFF_STAT: reg_sel = 3'h2;
        `LUS_OFF_TXD:  reg_sel = 3'h3;
        `LUS_OFF_RXD:  reg_sel = 3'h4;
        `LUS_OFF_EXT:  reg_sel = 3'h5;
        `LUS_OFF_BAUD: reg_sel = 3'h6;
        default:       reg_sel = 3'h7;
      endcase
    end
  endfunction

  reg         aw_full_reg, w_full_reg;
  reg  [7:0]  aw_addr_reg;
  reg  [31:0] wdata_reg;
  reg         wstrb0_reg;
  reg         txen_reg, rxen_reg, ad_reg, msb_reg, ch7_reg;
  reg  [1:0]  mode_reg;
  reg         txie_reg, brkie_reg, brkedge_reg, rxprot_reg, startopt_reg;
  reg         hdrtx_reg, slave_reg;
  reg  [1:0]  blen_reg;
  reg  [15:0] baud_reg;
  reg  [1:0]  tx_st_reg, rx_st_reg, hdr_st_reg;
  reg  [15:0] tx_tmr_reg, rx_tmr_reg;
  reg  [4:0]  tx_cnt_reg;
  reg  [3:0]  rx_cnt_reg;
  reg  [7:0]  tdr_reg, tx_byte_reg, rx_sh_reg, rdr_reg;
  reg         tx_ad_reg, txempty_reg, brk_pend_reg, tx_out_reg;
  reg         rx_adb_reg, rxfull_reg, framerr_reg, rxadb_reg;
  reg         brkdet_reg, brk_lock_reg;
  reg  [15:0] brk_pre_reg, idle_pre_reg;
  reg  [3:0]  brk_bits_reg, idle_bits_reg;
  reg         idle_reg;
  reg         tx_bit;
  reg  [31:0] rd_mux;
  wire        rx_lvl, rx_fall;

  lus_pin_sync u_rx_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_in    (serial_receive_input),
    .level_reg (rx_lvl),
    .fall_reg  (rx_fall)
  );

  // =====================================================================
  // bus slave: address and data taken in either order, then one response
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire       wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire       rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire [2:0] wsel  = reg_sel(aw_addr_reg);
  wire [2:0] rsel  = reg_sel(s_axi_araddr);

  always @(posedge ref_clk) begin
    if (rst) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      wdata_reg    <= 32'h00000000;
      wstrb0_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LUS_RESP_OK;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wsel == 3'h7) ? `LUS_RESP_ERR : `LUS_RESP_OK;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write strobes; all registers fit byte lane 0 or are written whole
  wire wr_en   = wr_go & wstrb0_reg;
  wire wr_ctrl = wr_en & (wsel == 3'h0);
  wire wr_adsc = wr_en & (wsel == 3'h1);
  wire wr_stat = wr_en & (wsel == 3'h2);
  wire wr_txd  = wr_en & (wsel == 3'h3);
  wire wr_ext  = wr_en & (wsel == 3'h5);
  wire wr_baud = wr_en & (wsel == 3'h6);
  wire rd_rxd  = rd_go & (rsel == 3'h4);
  wire clr_err = wr_ctrl & wdata_reg[`LUS_CTL_CLRERR];
  wire port_rst = wr_ctrl & wdata_reg[`LUS_CTL_PRST];
  wire mode_chg = wr_ctrl &
                  (wdata_reg[`LUS_CTL_MODE_HI:`LUS_CTL_MODE_LO] != mode_reg);

  // =====================================================================
  // configuration registers
  always @(posedge ref_clk) begin
    if (rst) begin
      txen_reg <= 1'b0;
      rxen_reg <= 1'b0;
      ad_reg <= 1'b0;
      mode_reg <= `LUS_MODE_ASYNC;
      msb_reg <= 1'b0;
      ch7_reg <= 1'b0;
      txie_reg <= 1'b0;
      brkie_reg <= 1'b0;
      {brkedge_reg, rxprot_reg, startopt_reg, hdrtx_reg, slave_reg} <= 5'h00;
      blen_reg <= 2'h0;
      baud_reg <= `LUS_BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        txen_reg <= wdata_reg[`LUS_CTL_TXEN];
        rxen_reg <= wdata_reg[`LUS_CTL_RXEN];
        ad_reg   <= wdata_reg[`LUS_CTL_ADSEL];
        mode_reg <= wdata_reg[`LUS_CTL_MODE_HI:`LUS_CTL_MODE_LO];
        msb_reg  <= wdata_reg[`LUS_CTL_MSB];
        ch7_reg  <= wdata_reg[`LUS_CTL_CH7];
      end
      // set strobe wins over clear strobe
      if (wr_adsc & wdata_reg[`LUS_ADSC_CLR]) ad_reg <= 1'b0;
      if (wr_adsc & wdata_reg[`LUS_ADSC_SET]) ad_reg <= 1'b1;
      if (wr_stat) begin
        txie_reg  <= wdata_reg[`LUS_ST_TXIE];
        brkie_reg <= wdata_reg[`LUS_ST_BRKIE];
      end
      if (wr_ext) begin
        brkedge_reg  <= wdata_reg[`LUS_EXT_BRKEDGE];
        rxprot_reg   <= wdata_reg[`LUS_EXT_RXPROT];
        startopt_reg <= wdata_reg[`LUS_EXT_STARTOPT];
        hdrtx_reg    <= wdata_reg[`LUS_EXT_HDRTX];
        slave_reg    <= wdata_reg[`LUS_EXT_SLAVE];
        blen_reg     <= wdata_reg[`LUS_EXT_BLEN_HI:`LUS_EXT_BLEN_LO];
      end
      if (wr_baud) baud_reg <= wdata_reg[15:0];
    end
  end

  // =====================================================================
  // frame format; LIN mode overrides length, address bit and order
  wire       lin     = (mode_reg == `LUS_MODE_LIN);
  wire [3:0] nd      = (lin | ~ch7_reg) ? 4'h8 : 4'h7;
  wire       has_ad  = (mode_reg == `LUS_MODE_MULTI);
  wire       msb_eff = msb_reg & ~lin;
  wire [4:0] tx_stop = {1'b0, nd} + {4'h0, has_ad} + 5'h01;
  wire [4:0] brk_len = `LUS_BRK_TX_BASE + {3'h0, blen_reg};
  wire [15:0] half   = {1'b0, baud_reg[15:1]};

  // =====================================================================
  // transmitter
  wire tx_run  = txen_reg | (lin & hdrtx_reg);
  wire tx_tick = (tx_tmr_reg == 16'h0000);
  wire [3:0] tx_im = nd - tx_cnt_reg[3:0];
  wire [3:0] tx_il = tx_cnt_reg[3:0] - 4'h1;

  // bit on the wire for the current slot of a data frame
  always @* begin
    tx_bit = 1'b1;
    if (tx_cnt_reg == 5'h00) begin
      tx_bit = 1'b0;
    end else if (tx_cnt_reg <= {1'b0, nd}) begin
      tx_bit = msb_eff ? tx_byte_reg[tx_im[2:0]] : tx_byte_reg[tx_il[2:0]];
    end else if (has_ad & (tx_cnt_reg == {1'b0, nd} + 5'h01)) begin
      tx_bit = tx_ad_reg;
    end
  end

  // pending data is served before a pending break, so an early id goes first
  always @(posedge ref_clk) begin
    if (rst | port_rst) begin
      tx_st_reg <= T_IDLE;
      tx_out_reg <= 1'b1;
      tx_tmr_reg <= 16'h0000;
      tx_cnt_reg <= 5'h00;
      tx_byte_reg <= `LUS_TDR_RST;
      tdr_reg <= `LUS_TDR_RST;
      tx_ad_reg <= 1'b0;
      txempty_reg <= 1'b1;
      brk_pend_reg <= 1'b0;
    end else begin
      if (mode_chg | ~tx_run) begin
        tx_st_reg  <= T_IDLE;
        tx_out_reg <= 1'b1;
      end else begin
        case (tx_st_reg)
          T_IDLE: begin
            tx_out_reg <= 1'b1;
            tx_tmr_reg <= baud_reg;
            tx_cnt_reg <= 5'h00;
            if (~txempty_reg) begin
              tx_st_reg   <= T_SHIFT;
              tx_byte_reg <= tdr_reg;
              tx_ad_reg   <= ad_reg;
              txempty_reg <= 1'b1;
            end else if (brk_pend_reg) begin
              tx_st_reg    <= T_BRK;
              brk_pend_reg <= 1'b0;
            end
          end
          T_BRK: begin
            tx_out_reg <= 1'b0;
            tx_tmr_reg <= tx_tick ? baud_reg : tx_tmr_reg - 16'h0001;
            if (tx_tick) begin
              tx_cnt_reg <= tx_cnt_reg + 5'h01;
              if (tx_cnt_reg == brk_len - 5'h01) begin
                tx_st_reg  <= T_DEL;
                tx_cnt_reg <= 5'h00;
              end
            end
          end
          T_DEL: begin
            tx_out_reg <= 1'b1;
            tx_tmr_reg <= tx_tick ? baud_reg : tx_tmr_reg - 16'h0001;
            if (tx_tick) begin
              tx_st_reg   <= T_SHIFT;
              tx_byte_reg <= `LUS_SYNC_BYTE;
              tx_ad_reg   <= 1'b0;
            end
          end
          T_SHIFT: begin
            tx_out_reg <= tx_bit;
            tx_tmr_reg <= tx_tick ? baud_reg : tx_tmr_reg - 16'h0001;
            if (tx_tick) begin
              tx_cnt_reg <= tx_cnt_reg + 5'h01;
              if (tx_cnt_reg == tx_stop) tx_st_reg <= T_IDLE;
            end
          end
          default: tx_st_reg <= T_IDLE;
        endcase
      end
      // a new write wins over the load of the previous byte
      if (wr_txd) begin
        tdr_reg     <= wdata_reg[7:0];
        txempty_reg <= 1'b0;
      end
      if (wr_ext & wdata_reg[`LUS_EXT_BRKREQ] & lin & hdrtx_reg) begin
        brk_pend_reg <= 1'b1;
      end
    end
  end

  // =====================================================================
  // break detector, background in LIN mode, locked once it fires
  // a falling edge restarts the count and is itself the first low clock
  wire        brk_restart = brkedge_reg ? rx_fall : rx_lvl;
  wire        brk_zero    = ~lin | brk_lock_reg | brk_restart;
  wire [15:0] brk_pre     = brk_zero ? 16'h0000 : brk_pre_reg;
  wire [3:0]  brk_bits    = brk_zero ? 4'h0 : brk_bits_reg;
  wire        brk_wrap    = (brk_pre == baud_reg);
  wire        brk_set     = lin & ~brk_lock_reg & ~rx_lvl & brk_wrap &
                            (brk_bits == `LUS_BRK_RX_BITS - 4'h1);

  always @(posedge ref_clk) begin
    if (rst | port_rst) begin
      brkdet_reg   <= 1'b0;
      brk_lock_reg <= 1'b0;
      brk_pre_reg  <= 16'h0000;
      brk_bits_reg <= 4'h0;
    end else if (lin & ~brk_lock_reg & ~rx_lvl) begin
      brk_pre_reg  <= brk_wrap ? 16'h0000 : brk_pre + 16'h0001;
      brk_bits_reg <= brk_wrap ? brk_bits + 4'h1 : brk_bits;
      if (brk_set) begin
        brkdet_reg   <= 1'b1;
        brk_lock_reg <= 1'b1;
      end
    end else if (brk_zero) begin
      brk_pre_reg  <= 16'h0000;
      brk_bits_reg <= 4'h0;
    end
  end

  // =====================================================================
  // header reception: break, then sync field, then identifier
  wire       rx_tick = (rx_tmr_reg == 16'h0000);
  wire       rx_run  = rxen_reg | (lin & (hdr_st_reg != H_IDLE));
  wire       rx_kill = port_rst | (clr_err & ~rxprot_reg) | ~rx_run |
                       mode_chg | brk_set;
  wire       rx_done = (rx_st_reg == R_STOP) & rx_tick & ~rx_kill;
  wire [7:0] rx_byte = msb_eff ? rx_sh_reg :
                       ((nd == 4'h7) ? {1'b0, rx_sh_reg[7:1]} : rx_sh_reg);

  always @(posedge ref_clk) begin
    if (rst | port_rst | ~lin) begin
      hdr_st_reg <= H_IDLE;
    end else begin
      case (hdr_st_reg)
        H_IDLE:  if (brk_set) hdr_st_reg <= H_SYNC;
        H_SYNC:  if (rx_done) begin
          hdr_st_reg <= (rx_byte == `LUS_SYNC_BYTE) ? H_ID : H_IDLE;
        end
        H_ID:    if (rx_done) hdr_st_reg <= H_IDLE;
        default: hdr_st_reg <= H_IDLE;
      endcase
    end
  end

  // =====================================================================
  // receiver; a reset leaves it waiting for the next falling edge
  always @(posedge ref_clk) begin
    if (rst | rx_kill) begin
      rx_st_reg  <= R_IDLE;
      rx_tmr_reg <= 16'h0000;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg  <= 8'h00;
      rx_adb_reg <= 1'b0;
    end else begin
      rx_tmr_reg <= rx_tick ? baud_reg : rx_tmr_reg - 16'h0001;
      case (rx_st_reg)
        R_IDLE: if (rx_fall) begin
          rx_st_reg  <= R_START;
          rx_tmr_reg <= half;
        end
        R_START: if (rx_tick) begin
          rx_st_reg  <= rx_lvl ? R_IDLE : R_DATA;
          rx_cnt_reg <= 4'h0;
          rx_sh_reg  <= 8'h00;
        end
        R_DATA: if (rx_tick) begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg >= nd) rx_adb_reg <= rx_lvl;
          else if (msb_eff) rx_sh_reg <= {rx_sh_reg[6:0], rx_lvl};
          else rx_sh_reg <= {rx_lvl, rx_sh_reg[7:1]};
          if (rx_cnt_reg == nd + {3'h0, has_ad} - 4'h1) rx_st_reg <= R_STOP;
        end
        R_STOP: if (rx_tick) begin
          // low stop runs straight into the next start slot unless startopt_reg is set
          rx_st_reg <= (~rx_lvl & ~startopt_reg) ? R_START : R_IDLE;
        end
        default: rx_st_reg <= R_IDLE;
      endcase
    end
  end

  // receive data and flags; hardware set wins over software clear, for the error flag only with rxprot_reg set
  always @(posedge ref_clk) begin
    if (rst | port_rst) begin
      rdr_reg     <= `LUS_RDR_RST;
      rxfull_reg  <= 1'b0;
      framerr_reg <= 1'b0;
      rxadb_reg   <= 1'b0;
    end else begin
      if (rd_rxd) rxfull_reg <= 1'b0;
      if (clr_err) framerr_reg <= 1'b0;
      if (rx_done) begin
        if (~rx_lvl) framerr_reg <= 1'b1;
        if (hdr_st_reg != H_SYNC) begin
          rdr_reg    <= rx_byte;
          rxfull_reg <= 1'b1;
          rxadb_reg  <= rx_adb_reg;
        end
      end
    end
  end

  // =====================================================================
  // bus idle, unavailable as synchronous slave
  wire idle_off  = (mode_reg == `LUS_MODE_SYNC) & slave_reg;
  wire idle_wrap = (idle_pre_reg == baud_reg);

  always @(posedge ref_clk) begin
    if (rst | idle_off | ~rx_lvl) begin
      idle_reg      <= 1'b0;
      idle_pre_reg  <= 16'h0000;
      idle_bits_reg <= 4'h0;
    end else if (~idle_reg) begin
      idle_pre_reg <= idle_wrap ? 16'h0000 : idle_pre_reg + 16'h0001;
      if (idle_wrap) idle_bits_reg <= idle_bits_reg + 4'h1;
      if (idle_wrap & (idle_bits_reg == `LUS_IDLE_BITS - 4'h1)) idle_reg <= 1'b1;
    end
  end

  // =====================================================================
  // read mux and response; reading receive data frees it
  always @* begin
    rd_mux = 32'h00000000;
    case (rsel)
      3'h0: rd_mux[8:0] = {ch7_reg, msb_reg, 1'b0, mode_reg, ad_reg, 1'b0,
                           rxen_reg | (hdr_st_reg == H_ID), txen_reg};
      3'h2: rd_mux[7:0] = {idle_reg, brkie_reg, txie_reg, rxadb_reg,
                           brkdet_reg, framerr_reg, rxfull_reg, txempty_reg};
      3'h4: rd_mux[7:0] = rdr_reg;
      3'h5: rd_mux[7:0] = {blen_reg, slave_reg, 1'b0, hdrtx_reg, startopt_reg,
                           rxprot_reg, brkedge_reg};
      3'h6: rd_mux[15:0] = baud_reg;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `LUS_RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (rsel == 3'h7) ? `LUS_RESP_ERR : `LUS_RESP_OK;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // =====================================================================
  // outputs; interrupt requests are levels built from flag flops
  assign serial_transmit_output = tx_out_reg;
  assign tx_irq    = txie_reg & txempty_reg;
  assign break_irq = brkie_reg & brkdet_reg;
endmodule // lus_top

/* verif/lus_monitor.sv */
`timescale 1ns/1ps
// ==========
// port checks beside the top block
module lus_monitor (
  input wire        ref_clk,
  input wire        rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire        serial_receive_input,
  input wire        serial_transmit_output,
  input wire        break_irq
);
  localparam int BRK = 36; // ten bits of four clocks, less sync slack
  logic [7:0] lo_reg;
  logic [2:0] hi_reg;
  // low run length; six high clocks end a run, so sync lag is forgiven
  always @(posedge ref_clk) begin
    if (rst || hi_reg == 3'h6)
      lo_reg <= 8'h00;
    else if (!serial_receive_input && lo_reg != 8'hFF)
      lo_reg <= lo_reg + 8'h01;
    if (rst || !serial_receive_input)
      hi_reg <= 3'h0;
    else if (hi_reg != 3'h6)
      hi_reg <= hi_reg + 3'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_TX_RST: assert property ($fell(rst) |-> serial_transmit_output && !break_irq)
    else $error("bad idle after reset");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready too early");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  AST_AR_BLOCK: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18
    |=> s_axi_rdata == 32'h0)
    else $error("unmapped read data");
  AST_BRK_LOW: assert property ($rose(break_irq) && !s_axi_bvalid |-> lo_reg >= BRK)
    else $error("break flag too soon");
  AST_BRK_HOLD: assert property ($fell(break_irq) |-> s_axi_bvalid)
    else $error("break flag lost");
  COV_WR: cover property (s_axi_awvalid && s_axi_awready);
  COV_RD: cover property (s_axi_arvalid && s_axi_arready);
  COV_BRK: cover property ($rose(break_irq));
endmodule // lus_monitor
bind lus_top lus_monitor u_mon (
  .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
  .serial_receive_input(serial_receive_input),
  .serial_transmit_output(serial_transmit_output), .break_irq(break_irq)
);

/* verif/lus_peer.sv */
`timescale 1ns/1ps
// ==========
// serial peer: drives the line, decodes frames sent to it
module lus_peer #(parameter int BIT_CLKS = 4) (
  input  wire        ref_clk,
  input  wire        tx_line,
  output logic       rx_line,
  output logic [7:0] byte_seen,
  output logic       byte_stb
);
  initial begin
    rx_line = 1'b1;
    byte_stb = 1'b0;
    byte_seen = 8'h00;
  end
  // dominant for n bit times, then one recessive bit
  task automatic send_low(input int n);
    @(posedge ref_clk);
    rx_line <= 1'b0;
    repeat (n * BIT_CLKS) @(posedge ref_clk);
    rx_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge ref_clk);
  endtask
  // one 8N1 frame lsb first; two stop bit times give the receiver room
  task automatic send_byte(input logic [7:0] d);
    @(posedge ref_clk);
    rx_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      rx_line <= d[i];
      repeat (BIT_CLKS) @(posedge ref_clk);
    end
    rx_line <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge ref_clk);
  endtask
  // lsb first, sampled mid bit; a low stop gives no strobe
  initial forever begin
    @(negedge tx_line);
    repeat (BIT_CLKS / 2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge ref_clk);
      byte_seen[i] <= tx_line;
    end
    repeat (BIT_CLKS) @(posedge ref_clk);
    byte_stb <= tx_line;
    @(posedge ref_clk);
    byte_stb <= 1'b0;
  end
endmodule // lus_peer

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "lus_consts.vh"
// ==========
// bench: reads and peer bytes checked against queued notes
module testbench;
  logic        ref_clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rx_line, tx_line, tx_irq, break_irq, pk_stb;
  wire  [7:0]  pk_byte;
  logic [31:0] rq[$], tq[$];
  int          n_errors = 0, checks_done = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  // ready inputs raised with each request, dropped once the answer is taken
  lus_top u_dut (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .serial_receive_input(rx_line),
    .serial_transmit_output(tx_line), .tx_irq(tx_irq), .break_irq(break_irq)
  );
  lus_peer u_peer (
    .ref_clk(ref_clk), .tx_line(tx_line), .rx_line(rx_line),
    .byte_seen(pk_byte), .byte_stb(pk_stb)
  );
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask
  // samples the chosen request line one edge later, where it has settled
  task automatic irq(input logic brk, input logic e);
    @(posedge ref_clk);
    chk("irq", {31'h0, brk ? break_irq : tx_irq}, {31'h0, e});
  endtask
  // watcher and hang limit
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk("read", s_axi_rdata, rq.pop_front());
    if (pk_stb && tq.size() > 0)
      chk("byte", {24'h0, pk_byte}, tq.pop_front());
  end
  initial begin
    logic [7:0] b, r;
    void'($urandom(98951));
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(`LUS_OFF_CTRL, 32'h0);
    wr(`LUS_OFF_BAUD, $urandom, 4'hE);
    rd(`LUS_OFF_BAUD, 32'h043C);
    rd(8'h1C, 32'h0);
    wr(`LUS_OFF_STAT, 32'h20);
    irq(1'b0, 1'b1);
    wr(`LUS_OFF_STAT, 32'h0);
    wr(`LUS_OFF_ADSC, 32'h1);
    rd(`LUS_OFF_CTRL, 32'h8);
    wr(`LUS_OFF_ADSC, 32'h2);
    rd(`LUS_OFF_CTRL, 32'h0);
    $display("register test done");
    wr(`LUS_OFF_BAUD, 32'h3);
    // lsb first, msb first, then mode 3 overriding msb first
    for (int m = 0; m < 3; m++) begin
      b = 8'($urandom);
      for (int k = 0; k < 8; k++)
        r[k] = (m == 1) ? b[7 - k] : b[k];
      wr(`LUS_OFF_CTRL, (m == 0) ? 32'h01 : (m == 1) ? 32'h81 : 32'hB1);
      tq.push_back({24'h0, r});
      wr(`LUS_OFF_TXD, {24'h0, b});
      for (int w = 0; w < 200 && tq.size() > 0; w++)
        @(posedge ref_clk);
      wr(`LUS_OFF_CTRL, 32'h0);
    end
    $display("frame test done");
    // mode 3 with both enables off still sees breaks and whole headers
    wr(`LUS_OFF_CTRL, 32'h30);
    wr(`LUS_OFF_STAT, 32'h40);
    u_peer.send_low(10);
    irq(1'b1, 1'b1);
    b = 8'($urandom);
    u_peer.send_byte(`LUS_SYNC_BYTE);
    rd(`LUS_OFF_CTRL, 32'h32);
    u_peer.send_byte(b);
    rd(`LUS_OFF_RXD, {24'h0, b});
    rd(`LUS_OFF_CTRL, 32'h30);
    u_peer.send_low(12);
    irq(1'b1, 1'b1);
    wr(`LUS_OFF_CTRL, 32'h70);
    irq(1'b1, 1'b0);
    u_peer.send_low(9);
    irq(1'b1, 1'b0);
    u_peer.send_low(6);
    u_peer.send_low(6);
    irq(1'b1, 1'b0);
    // edge start: ten low bits still count, a second fall restarts
    wr(`LUS_OFF_EXT, 32'h1);
    u_peer.send_low(10);
    irq(1'b1, 1'b1);
    wr(`LUS_OFF_CTRL, 32'h70);
    u_peer.send_low(6);
    u_peer.send_low(6);
    irq(1'b1, 1'b0);
    $display("break test done");
    chk("pending", tq.size() + rq.size(), 32'h0);
    end_of_test();
  end
endmodule // testbench
